// file: pscs_pkg.sv
// Package: constants and types of the periodic self-check sequencer
// Contract
// [RQ1] Timing from 0.976 ms tick counter chain
// [RQ2] Manual or automatic trigger, one common stage
// [RQ3] Strap absent disables automatic trigger path
// [RQ4] Alarms held inactive for whole test
// [RQ5] Mute pulse about six seconds, zeroes outputs
// [RQ6] Manual presses ignored while mute asserted
// [RQ7] Counter pulse clears integrator at start
// [RQ8] Latch-enable strobe fixed time after trigger
// [RQ9] Latch changes only on enable strobe
// [RQ10] On strobe, fail result latches fail
// [RQ11] Threshold reads fail after power-up
// [RQ12] Fail when ramp-top level below limit
// [RQ13] Pass lights lamp, energizes relay; fail not
// [RQ14] Automatic test every 17.1 minutes
// [RQ15] Manual test restarts automatic interval timer
// [RQ16] Test timings are tick-count parameters
package pscs_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned TICK_PERIOD_NS  = 976_000;
    localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned MUTE_MS         = 6000;
    localparam int unsigned MUTE_TICKS      = (MUTE_MS * 1000) / 976;
    localparam int unsigned CLEAR_TICKS     = 1;
    localparam int unsigned STROBE_TICKS    = MUTE_TICKS - 2;
    localparam int unsigned AUTO_TENTHS_MIN = 171;
    localparam int unsigned AUTO_TICKS      = (AUTO_TENTHS_MIN * 6000 * 1000) / 976;
    localparam int unsigned CNT_W           = 24;
    localparam int unsigned SYNC_STAGES     = 3;
    localparam logic        RESULT_RESET    = 1'b1;
    typedef enum logic [1:0] {PSCS_IDLE, PSCS_TEST} pscs_state_t;
endpackage : pscs_pkg

// file: pscs_tick_if.sv
// Interface: tick carried from the tick generator to the sequencer
interface pscs_tick_if;
    logic tick;
    modport gen (output tick);
    modport use_side (input tick);
endinterface : pscs_tick_if

// file: pscs_tick_gen.sv
// Tick generator: one-cycle pulse every 0.976 ms
module pscs_tick_gen
    import pscs_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input  wire logic      clk,
    input  wire logic      reset_n,
    pscs_tick_if.gen       tk
);
    logic [CNT_W-1:0] div_q;
    logic [CNT_W-1:0] div_d;
    logic             tick_q;
    logic             tick_d;

    always_comb begin
        tick_d = 1'b0;
        div_d  = div_q + 24'h000001;
        if (div_q >= CNT_W'(TICK_DIV - 1)) begin
            div_d  = 24'h000000;
            tick_d = 1'b1; // RQ1
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_q  <= 24'h000000;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;
endmodule : pscs_tick_gen

// file: pscs_sequencer.sv
// Top: self-check test sequencer with mute, clear, strobe and pass/fail latch
module pscs_sequencer
    import pscs_pkg::*;
#(
    parameter int unsigned TICK_DIV     = TICK_CYCLES,
    parameter int unsigned MUTE_LEN     = MUTE_TICKS,
    parameter int unsigned CLEAR_LEN    = CLEAR_TICKS,
    parameter int unsigned STROBE_AT    = STROBE_TICKS,
    parameter int unsigned AUTO_PERIOD  = AUTO_TICKS
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic test_button,
    input  wire logic auto_test_strap,
    input  wire logic level_below_limit,
    output logic      test_mute,
    output logic      alarm_inhibit,
    output logic      analog_out_zero,
    output logic      ramp_start,
    output logic      integrator_clear,
    output logic      latch_enable,
    output logic      threshold_fail,
    output logic      fail_latched,
    output logic      safe_lamp,
    output logic      fail_relay_energized
);
    pscs_tick_if tk ();

    pscs_tick_gen #(.TICK_DIV(TICK_DIV)) u_tick (
        .clk     (clk),
        .reset_n (reset_n),
        .tk      (tk)
    );

    // Pin synchronisers
    logic [SYNC_STAGES-1:0] btn_sync_q;
    logic [SYNC_STAGES-1:0] btn_sync_d;
    logic [SYNC_STAGES-1:0] strap_sync_q;
    logic [SYNC_STAGES-1:0] strap_sync_d;
    logic [SYNC_STAGES-1:0] lvl_sync_q;
    logic [SYNC_STAGES-1:0] lvl_sync_d;
    logic                   btn_q;
    logic                   btn_d;
    logic                   strap_q;
    logic                   strap_d;
    logic                   lvl_q;
    logic                   lvl_d;

    always_comb begin
        btn_sync_d   = {btn_sync_q[SYNC_STAGES-2:0], test_button};
        strap_sync_d = {strap_sync_q[SYNC_STAGES-2:0], auto_test_strap};
        lvl_sync_d   = {lvl_sync_q[SYNC_STAGES-2:0], level_below_limit};
        btn_d   = (btn_sync_q[1] == btn_sync_q[2]) ? btn_sync_q[2] : btn_q;
        strap_d = (strap_sync_q[1] == strap_sync_q[2]) ? strap_sync_q[2] : strap_q;
        lvl_d   = (lvl_sync_q[1] == lvl_sync_q[2]) ? lvl_sync_q[2] : lvl_q;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            btn_sync_q   <= 3'h0;
            strap_sync_q <= 3'h0;
            lvl_sync_q   <= 3'h0;
            btn_q        <= 1'b0;
            strap_q      <= 1'b0;
            lvl_q        <= 1'b0;
        end else begin
            btn_sync_q   <= btn_sync_d;
            strap_sync_q <= strap_sync_d;
            lvl_sync_q   <= lvl_sync_d;
            btn_q        <= btn_d;
            strap_q      <= strap_d;
            lvl_q        <= lvl_d;
        end
    end

    // Trigger stage: manual edge or automatic interval, one common path
    pscs_state_t      state_q;
    logic [CNT_W-1:0] auto_cnt_q;
    logic [CNT_W-1:0] auto_cnt_d;
    logic             btn_prev_q;
    logic             btn_prev_d;
    logic             manual_trig;
    logic             auto_trig;
    logic             trigger;

    always_comb begin
        manual_trig = btn_q && !btn_prev_q && (state_q == PSCS_IDLE); // RQ6
        auto_trig   = strap_q && tk.tick
                      && (auto_cnt_q >= CNT_W'(AUTO_PERIOD - 1)); // RQ3 RQ14
        trigger     = (manual_trig || auto_trig) && (state_q == PSCS_IDLE); // RQ2
        btn_prev_d  = btn_q;
        auto_cnt_d  = auto_cnt_q;
        // Interval restarts from zero after every test and while the strap is out
        if (trigger || !strap_q) begin
            auto_cnt_d = 24'h000000; // RQ15
        end else if (tk.tick && state_q == PSCS_IDLE) begin
            auto_cnt_d = auto_cnt_q + 24'h000001; // RQ1
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            auto_cnt_q <= 24'h000000;
            btn_prev_q <= 1'b1;
        end else begin
            auto_cnt_q <= auto_cnt_d;
            btn_prev_q <= btn_prev_d;
        end
    end

    // Sequence counter and one-shots: mute window, integrator clear, strobe
    pscs_state_t      state_d;
    logic [CNT_W-1:0] seq_cnt_q;
    logic [CNT_W-1:0] seq_cnt_d;
    logic [CNT_W-1:0] seq_next;
    logic             ramp_q;
    logic             ramp_d;
    logic             clear_q;
    logic             clear_d;
    logic             strobe_q;
    logic             strobe_d;

    always_comb begin
        seq_next  = seq_cnt_q + 24'h000001;
        state_d   = state_q;
        seq_cnt_d = seq_cnt_q;
        ramp_d    = trigger;
        clear_d   = clear_q;
        strobe_d  = 1'b0;
        case (state_q)
            PSCS_IDLE: begin
                if (trigger) begin
                    state_d   = PSCS_TEST;
                    seq_cnt_d = 24'h000000;
                    clear_d   = 1'b1; // RQ7
                end
            end
            PSCS_TEST: begin
                // First tick of a manual test may be partial: a manual trigger is not tick-aligned
                if (tk.tick) begin
                    seq_cnt_d = seq_next; // RQ1 RQ16
                    if (seq_next >= CNT_W'(CLEAR_LEN)) begin
                        clear_d = 1'b0; // RQ7
                    end
                    if (seq_next == CNT_W'(STROBE_AT)) begin
                        strobe_d = 1'b1; // RQ8
                    end
                    if (seq_next >= CNT_W'(MUTE_LEN)) begin
                        state_d = PSCS_IDLE; // RQ5
                        clear_d = 1'b0;
                    end
                end
            end
            default: begin
                state_d = PSCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q   <= PSCS_IDLE;
            seq_cnt_q <= 24'h000000;
            ramp_q    <= 1'b0;
            clear_q   <= 1'b0;
            strobe_q  <= 1'b0;
        end else begin
            state_q   <= state_d;
            seq_cnt_q <= seq_cnt_d;
            ramp_q    <= ramp_d;
            clear_q   <= clear_d;
            strobe_q  <= strobe_d;
        end
    end

    // Threshold result and pass/fail latch
    logic             result_q;
    logic             result_d;
    logic             latch_q;
    logic             latch_d;

    always_comb begin
        result_d = result_q;
        latch_d  = latch_q;
        // Clear beats the level so a fail from the last test cannot carry over
        if (state_q == PSCS_TEST) begin
            if (clear_q) begin
                result_d = 1'b0; // RQ7
            end else if (lvl_q) begin
                result_d = 1'b1; // RQ12
            end
        end
        if (strobe_q) begin
            latch_d = result_q; // RQ9 RQ10
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            result_q <= RESULT_RESET; // RQ11
            latch_q  <= 1'b0;
        end else begin
            result_q <= result_d;
            latch_q  <= latch_d;
        end
    end

    // Mute is the test-running state itself
    always_comb begin
        test_mute            = (state_q == PSCS_TEST); // RQ5
        alarm_inhibit        = (state_q == PSCS_TEST); // RQ4
        analog_out_zero      = (state_q == PSCS_TEST); // RQ5
        ramp_start           = ramp_q;
        integrator_clear     = clear_q;
        latch_enable         = strobe_q;
        threshold_fail       = result_q;
        fail_latched         = latch_q;
        safe_lamp            = !latch_q; // RQ13
        fail_relay_energized = !latch_q; // RQ13
    end
endmodule : pscs_sequencer

// file: pscs_checker.sv
// Checker: port assertions of the self-check sequencer
module pscs_checker #(
    parameter int unsigned TICK_DIV  = 4,
    parameter int unsigned MUTE_LEN  = 20,
    parameter int unsigned STROBE_AT = 18
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic test_mute,
    input wire logic alarm_inhibit,
    input wire logic analog_out_zero,
    input wire logic ramp_start,
    input wire logic integrator_clear,
    input wire logic latch_enable,
    input wire logic threshold_fail,
    input wire logic fail_latched,
    input wire logic safe_lamp,
    input wire logic fail_relay_energized
);
    localparam int MUTE_LO = (MUTE_LEN - 1) * TICK_DIV;
    localparam int MUTE_HI = MUTE_LEN * TICK_DIV + 2;
    localparam int STB_LO  = (STROBE_AT - 1) * TICK_DIV;
    localparam int STB_HI  = STROBE_AT * TICK_DIV + 3;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_mute_all_outputs:
        assert property (alarm_inhibit == test_mute && analog_out_zero == test_mute)
        else $error("mute outputs disagree");
    a_start_pulses:
        assert property ($rose(test_mute) |-> (ramp_start && integrator_clear)
            ##1 (!ramp_start && !threshold_fail)) else $error("start pulses wrong");
    a_mute_length:
        assert property ($rose(test_mute) |-> ##[MUTE_LO:MUTE_HI] $fell(test_mute))
        else $error("mute length wrong");
    a_strobe_time:
        assert property ($rose(test_mute) |-> ##[STB_LO:STB_HI] latch_enable)
        else $error("strobe time wrong");
    a_strobe_inside:
        assert property (latch_enable |-> test_mute && !integrator_clear)
        else $error("strobe outside test");
    a_latch_hold:
        assert property ($changed(fail_latched) |-> $past(latch_enable))
        else $error("latch moved without strobe");
    a_latch_takes:
        assert property (latch_enable |=> fail_latched == $past(threshold_fail))
        else $error("latch missed result");
    a_lamp_relay:
        assert property (safe_lamp == !fail_latched && fail_relay_energized == !fail_latched)
        else $error("lamp or relay wrong");
    a_reset_fail:
        assert property ($rose(reset_n) |-> threshold_fail && !fail_latched)
        else $error("power-up result wrong");
endmodule : pscs_checker

bind pscs_sequencer pscs_checker #(.TICK_DIV(TICK_DIV), .MUTE_LEN(MUTE_LEN),
    .STROBE_AT(STROBE_AT)) u_chk (.clk(clk), .reset_n(reset_n), .test_mute(test_mute),
    .alarm_inhibit(alarm_inhibit), .analog_out_zero(analog_out_zero), .ramp_start(ramp_start),
    .integrator_clear(integrator_clear), .latch_enable(latch_enable),
    .threshold_fail(threshold_fail), .fail_latched(fail_latched), .safe_lamp(safe_lamp),
    .fail_relay_energized(fail_relay_energized));

// file: pscs_panel.sv
// Operator panel model: push button held for a few cycles per request
module pscs_panel (
    input  wire logic clk,
    input  wire logic push,
    output logic      test_button
);
    timeunit 1ns;
    timeprecision 1ns;
    int   hold = 0;
    logic req;
    initial test_button = 1'b0;
    always @(posedge clk) begin
        req = push;
        #2;
        if (req) hold = 6;
        test_button = hold > 0;
        if (hold > 0) hold--;
    end
endmodule : pscs_panel

// file: tb.sv
// Testbench: self-check sequencer driven through the panel model
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TD = 4;
    logic clk = 0, reset_n = 0, push = 0, strap = 0, lvl = 0, le_seen = 0, mute_d = 0;
    logic btn, mute, inh, azero, ramp, iclr, le, tf, fl, lamp, relay, e;
    logic exp_q[$];
    int   miscompares = 0, comparisons = 0, rises = 0, c;
    always #10 clk = ~clk;
    pscs_panel u_panel (.clk(clk), .push(push), .test_button(btn));
    pscs_sequencer #(.TICK_DIV(TD), .MUTE_LEN(20), .CLEAR_LEN(1), .STROBE_AT(18),
        .AUTO_PERIOD(50)) DUT (.clk(clk), .reset_n(reset_n), .test_button(btn),
        .auto_test_strap(strap), .level_below_limit(lvl), .test_mute(mute),
        .alarm_inhibit(inh), .analog_out_zero(azero), .ramp_start(ramp),
        .integrator_clear(iclr), .latch_enable(le), .threshold_fail(tf),
        .fail_latched(fl), .safe_lamp(lamp), .fail_relay_energized(relay));
    task automatic check(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic wait_mute(input logic v);
        c = 0;
        while (mute !== v) begin
            step(1);
            c++;
            if (c > 400) begin
                miscompares++;
                finish_test();
            end
        end
    endtask : wait_mute
    // A second press lands while muted and must leave no trace
    task automatic man_test(input logic l);
        int r;
        r = rises;
        lvl = l;
        exp_q.push_back(l);
        push = 1;
        step(1);
        push = 0;
        wait_mute(1);
        step(20);
        push = 1;
        step(1);
        push = 0;
        wait_mute(0);
        step(TD);
        check(rises == r + 1, 1'b1);
    endtask : man_test
    // Scoreboard: latch result one cycle after each strobe
    always @(negedge clk) begin
        if (le_seen) begin
            check(exp_q.size() > 0, 1'b1);
            e = exp_q.size() > 0 ? exp_q.pop_front() : 1'b0;
            check(fl, e);
            check(lamp, ~e);
            check(relay, ~e);
        end
        le_seen = le;
        if (mute === 1'b1 && mute_d === 1'b0) rises++;
        mute_d = mute;
    end
    initial begin
        void'($urandom(41));
        step(8);
        reset_n = 1;
        step(1);
        check(tf, 1'b1);
        check(lamp, 1'b1);
        step(300);
        check(rises == 0, 1'b1);
        man_test(1'b1);
        man_test(1'b0);
        strap = 1;
        step(120);
        man_test(1'b0);
        for (int i = 0; i < 3; i++) begin
            lvl = 1'($urandom % 2);
            exp_q.push_back(lvl);
            wait_mute(1);
            check(c >= 50 * TD - 8 && c <= 50 * TD + 8, 1'b1);
            wait_mute(0);
        end
        check(exp_q.size() == 0, 1'b1);
        finish_test();
    end
endmodule : tb
